// [snpb_regs.vh]
// snpb_regs.vh: offsets, field positions and reset values of the serial number and power budget bank
// assumes: included by the design files of this block only
`ifndef SNPB_REGS_VH
`define SNPB_REGS_VH

// =====================================================================
// register offsets (byte addresses)
`define SNPB_SN_HDR_OFS 12'h100
`define SNPB_SN_LO_OFS 12'h104
`define SNPB_SN_HI_OFS 12'h108
`define SNPB_PB_HDR_OFS 12'h138
`define SNPB_PB_IDX_OFS 12'h13c
`define SNPB_PB_DATA_OFS 12'h140
`define SNPB_PB_CAP_OFS 12'h144
// loader port for eeprom initialisation (own map)
`define SNPB_LD_CTRL_OFS 12'h180
`define SNPB_LD_DATA_OFS 12'h184

// =====================================================================
// header field values
`define SNPB_SN_CAP_ID 16'h0003
`define SNPB_PB_CAP_ID 16'h0004
`define SNPB_CAP_VER 4'h1
`define SNPB_SN_NEXT 12'hfb4
`define SNPB_PB_NEXT 12'h148

// =====================================================================
// field positions and reset values
`define SNPB_IDX_W 8
`define SNPB_IDX_RST 8'h00
`define SNPB_SYS_ALLOC_RST 1'b1
`define SNPB_SCALE_LSB 8
`define SNPB_SCALE_MSB 9
`define SNPB_PB_DATA_W 21
`define SNPB_PB_WORDS 8
// loader slot codes: 0..7 power words, 8 serial low, 9 serial high, 10 system allocated
`define SNPB_SLOT_SN_LO 4'h8
`define SNPB_SLOT_SN_HI 4'h9
`define SNPB_SLOT_CAP 4'ha

`endif

// [snpb_mem.v]
// snpb_mem.v: eight-word store for the power budget data words
// assumes: one clock, synchronous active-high reset, registered read data
`timescale 1ns/10ps
module snpb_mem #(
  parameter DW = 21,
  parameter AW = 3
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // write port
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [DW-1:0] wdata_i,
  // read port
  input wire [AW-1:0] raddr_i,
  output reg [DW-1:0] rdata_o
);
  reg [DW-1:0] mem_q [0:(1<<AW)-1];
  integer i;

  always @(posedge clk_i) begin
    if (rst_i) begin
      for (i = 0; i < (1<<AW); i = i + 1) begin
        mem_q[i] <= {DW{1'b0}};
      end
      rdata_o <= {DW{1'b0}};
    end else begin
      if (we_i) begin
        mem_q[waddr_i] <= wdata_i;
      end
      rdata_o <= mem_q[raddr_i];
    end
  end
endmodule // snpb_mem

// [snpb_bank.v]
// snpb_bank.v: serial number and power budget extended capability register bank
// assumes: classic wishbone slave, 32-bit data, byte addresses, single clock
// Function
// [RULE1] serial header id reads 0003h read-only
// [RULE2] both headers report version 1h
// [RULE3] serial header next pointer reads FB4h
// [RULE4] 104h returns serial number low word
// [RULE5] 108h returns serial number high word
// [RULE6] power budget header id reads 0004h
// [RULE7] power budget next pointer reads 148h
// [RULE8] 13Ch holds 8-bit rw index, reset 00h
// [RULE9] index 0..7 selects data words ascending
// [RULE10] writes to read-only fields change nothing
// [RULE11] index bits 31:8 read zero, ignore writes
// [RULE12] 140h presents word chosen by index
// [RULE13] scale field keeps its four encodings
// [RULE14] system allocated bit resets to one
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/10ps
`include "snpb_regs.vh"
module snpb_bank #(
  parameter AW = 12,
  parameter [31:0] SN_LO_RST = 32'h0000_0000, // arbitrary value
  parameter [31:0] SN_HI_RST = 32'h0000_0000 // arbitrary value
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [AW-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // status
  output wire init_done_o,
  output wire [`SNPB_IDX_W-1:0] pb_index_o
);

  // ===================================================================
  // state
  reg [`SNPB_IDX_W-1:0] idx_q;
  reg [31:0] sn_lo_q;
  reg [31:0] sn_hi_q;
  reg sys_alloc_q;
  reg init_done_q;
  reg rd_wait_q;
  wire req;
  wire [AW-1:0] a;
  wire wr;
  wire ld_wr;
  wire [3:0] ld_slot;
  wire [`SNPB_PB_DATA_W-1:0] pb_word;
  reg [31:0] rdat;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign a = {wb_adr_i[AW-1:2], 2'b00};
  assign wr = req & wb_we_i;
  assign pb_index_o = idx_q;
  assign init_done_o = init_done_q;

  // byte-lane merge
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        merge[k*8 +: 8] = sel[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
      end
    end
  endfunction

  // capability header builder
  function [31:0] cap_hdr;
    input [11:0] nxt;
    input [15:0] id;
    begin
      cap_hdr = {nxt, `SNPB_CAP_VER, id}; // RULE2
    end
  endfunction

  // ===================================================================
  // eeprom-style loader: ctrl write sets slot, data write loads it
  reg [3:0] slot_q;
  assign ld_slot = slot_q;
  assign ld_wr = wr & (a == `SNPB_LD_DATA_OFS) & ~init_done_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      slot_q <= 4'h0;
      init_done_q <= 1'b0;
    end else if (wr && a == `SNPB_LD_CTRL_OFS && !init_done_q) begin
      slot_q <= wb_dat_i[3:0];
      init_done_q <= wb_dat_i[31];
    end
  end

  snpb_mem #(
    .DW(`SNPB_PB_DATA_W),
    .AW(3)
  ) u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(ld_wr & ~ld_slot[3]),
    .waddr_i(ld_slot[2:0]),
    .wdata_i(wb_dat_i[`SNPB_PB_DATA_W-1:0]), // RULE13
    .raddr_i(idx_q[2:0]), // RULE9
    .rdata_o(pb_word)
  );

  // ===================================================================
  // writable registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      idx_q <= `SNPB_IDX_RST; // RULE8
      sn_lo_q <= SN_LO_RST;
      sn_hi_q <= SN_HI_RST;
      sys_alloc_q <= `SNPB_SYS_ALLOC_RST; // RULE14
    end else begin
      if (wr && a == `SNPB_PB_IDX_OFS && wb_sel_i[0]) begin
        idx_q <= wb_dat_i[7:0]; // RULE8 RULE11
      end
      if (ld_wr && ld_slot == `SNPB_SLOT_SN_LO) begin
        sn_lo_q <= merge(sn_lo_q, wb_dat_i, wb_sel_i); // RULE4
      end
      if (ld_wr && ld_slot == `SNPB_SLOT_SN_HI) begin
        sn_hi_q <= merge(sn_hi_q, wb_dat_i, wb_sel_i); // RULE5
      end
      if (ld_wr && ld_slot == `SNPB_SLOT_CAP) begin
        sys_alloc_q <= wb_dat_i[0];
      end
    end
  end

  // ===================================================================
  // read decode; all other offsets but 13Ch, 180h and 184h ignore writes
  always @* begin
    rdat = 32'h0000_0000;
    case (a)
      `SNPB_SN_HDR_OFS: rdat = cap_hdr(`SNPB_SN_NEXT, `SNPB_SN_CAP_ID); // RULE1 RULE3 RULE10
      `SNPB_SN_LO_OFS: rdat = sn_lo_q; // RULE4 RULE10
      `SNPB_SN_HI_OFS: rdat = sn_hi_q; // RULE5 RULE10
      `SNPB_PB_HDR_OFS: rdat = cap_hdr(`SNPB_PB_NEXT, `SNPB_PB_CAP_ID); // RULE6 RULE7
      `SNPB_PB_IDX_OFS: rdat = {24'h00_0000, idx_q}; // RULE11
      `SNPB_PB_DATA_OFS: rdat = (idx_q < `SNPB_PB_WORDS) ? {11'h000, pb_word} : 32'h0000_0000; // RULE12
      `SNPB_PB_CAP_OFS: rdat = {31'h0000_0000, sys_alloc_q}; // RULE14
      `SNPB_LD_CTRL_OFS: rdat = {init_done_q, 27'h000_0000, slot_q};
      default: rdat = 32'h0000_0000;
    endcase
  end

  // ===================================================================
  // wishbone answer: reads wait one cycle for memory data
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      rd_wait_q <= 1'b0;
    end else begin
      wb_ack_o <= 1'b0;
      if (req && wb_we_i) begin
        wb_ack_o <= 1'b1;
      end else if (req && !rd_wait_q) begin
        rd_wait_q <= 1'b1;
      end else if (req) begin
        rd_wait_q <= 1'b0;
        wb_ack_o <= 1'b1;
        wb_dat_o <= rdat;
      end else begin
        rd_wait_q <= 1'b0;
      end
    end
  end
endmodule // snpb_bank

// [snpb_bank_properties.sv]
// snpb_bank_properties.sv: port checks of the register bank
// assumes: bound to snpb_bank, one clock, sync reset
`timescale 1ns/10ps
module snpb_props #(
  parameter AW = 12
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // status
  input wire logic init_done_o,
  input wire logic [7:0] pb_index_o
);
  // ==========
  // checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire [9:0] dw = wb_adr_i[11:2];
  wire rd_ack = wb_ack_o & !wb_we_i;
  wire idx_wr = wb_cyc_i & wb_stb_i & wb_we_i & (dw == 10'h4f);
  sequence s_idx_take;
    idx_wr & !wb_ack_o & wb_sel_i[0];
  endsequence
  a_sn_header: assert property (rd_ack & dw == 10'h40 |-> wb_dat_o == 32'hfb41_0003)
    else $error("serial header wrong");
  a_pb_header: assert property (rd_ack & dw == 10'h4e |-> wb_dat_o == 32'h1481_0004)
    else $error("power header wrong");
  a_idx_reset: assert property ($fell(rst_i) |-> pb_index_o == 8'h00)
    else $error("index not cleared");
  a_idx_write: assert property (s_idx_take |=> pb_index_o == $past(wb_dat_i[7:0]))
    else $error("index not written");
  a_idx_hold: assert property (!idx_wr |=> $stable(pb_index_o))
    else $error("index changed");
  a_idx_rsvd: assert property (rd_ack & dw == 10'h4f |-> wb_dat_o == {24'h0, pb_index_o})
    else $error("index read wrong");
  a_data_rsvd: assert property (rd_ack & dw == 10'h50 |-> wb_dat_o[31:21] == 11'h0)
    else $error("data upper bits set");
  a_data_range: assert property (rd_ack & dw == 10'h50 & pb_index_o > 8'h07 |-> wb_dat_o == 32'h0)
    else $error("data for bad index");
  a_done_sticky: assert property (init_done_o |=> init_done_o)
    else $error("loader lock dropped");
endmodule // snpb_props
bind snpb_bank snpb_props #(.AW(AW)) i_snpb_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .init_done_o(init_done_o), .pb_index_o(pb_index_o));

// [tb.sv]
// tb.sv: self-checking bench of the register bank
// assumes: snpb_bank, wishbone master here, 40 MHz clock
`timescale 1ns/10ps
module tb;
  // ==========
  // signals and design
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [11:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0;
  logic [31:0] m [0:10];
  logic [31:0] q [$];
  wire [31:0] rdat;
  wire ack;
  wire done;
  wire [7:0] idx;
  int fail_count = 0, checks_done = 0, seed = 32'h0b66;
  initial forever #12.5 clk_i = ~clk_i;
  snpb_bank i_snpb_bank (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .init_done_o(done),
    .pb_index_o(idx));
  // ==========
  // tasks
  task report_and_stop;
    if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task wb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 0;
    stb <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    wb(0, a, $random(seed), 4'hf);
  endtask
  // read data checked against oldest note
  always @(posedge clk_i) if (ack === 1'b1 && !we) begin
    checks_done++;
    if (rdat !== q[0]) begin
      fail_count++;
      $display("wrong value at %0t: read %h want %h", $time, rdat, q[0]);
    end
    void'(q.pop_front());
  end
  // ==========
  // sequence
  initial begin
    int i;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    rd(12'h100, 32'hfb41_0003);
    rd(12'h138, 32'h1481_0004);
    rd(12'h13c, 0);
    rd(12'h144, 1);
    for (i = 0; i < 11; i++) begin
      m[i] = $random(seed);
      if (i < 8) m[i] = {11'h0, m[i][20:10], i[1:0], m[i][7:0]};
      wb(1, 12'h180, i, 4'hf);
      wb(1, 12'h184, m[i], 4'hf);
    end
    wb(1, 12'h104, ~m[8], 4'hf);
    wb(1, 12'h100, 0, 4'hf);
    rd(12'h104, m[8]);
    rd(12'h108, m[9]);
    rd(12'h100, 32'hfb41_0003);
    rd(12'h144, {31'h0, m[10][0]});
    for (i = 0; i < 8; i++) begin
      wb(1, 12'h13c, $random(seed) & 32'hffff_ff00 | i, 4'h1);
      checks_done++;
      if (idx !== i) begin
        fail_count++;
        $display("wrong value at %0t: index port %h want %h", $time, idx, i);
      end
      rd(12'h13c, i);
      rd(12'h140, m[i]);
    end
    wb(1, 12'h13c, 8, 4'he);
    rd(12'h13c, 7);
    wb(1, 12'h13c, 8, 4'h1);
    rd(12'h140, 0);
    rd(12'h1fc, 0);
    // lock the loader, then loader writes must be ignored
    wb(1, 12'h180, 32'h8000_0000, 4'hf);
    wb(1, 12'h184, 32'h001f_ffff, 4'hf);
    wb(1, 12'h180, 32'h0000_0003, 4'hf);
    checks_done++;
    if (done !== 1'b1) begin
      fail_count++;
      $display("wrong value at %0t: loader not locked", $time);
    end
    rd(12'h180, 32'h8000_0000);
    wb(1, 12'h13c, 0, 4'h1);
    rd(12'h140, m[0]);
    // second reset in mid-run
    @(posedge clk_i);
    rst_i <= 1;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    rd(12'h13c, 0);
    rd(12'h144, 1);
    rd(12'h180, 0);
    checks_done++;
    if (done !== 1'b0 || idx !== 8'h00) begin
      fail_count++;
      $display("wrong value at %0t: state after reset", $time);
    end
    @(posedge clk_i);
    @(posedge clk_i);
    report_and_stop;
  end
  initial begin
    #100000;
    fail_count++;
    report_and_stop;
  end
endmodule // tb
